// file: timer_out_pkg.sv
// What this block does
// - wave goes high after underflow, low after compare match
// - timers 2 and 3 also give an inverted copy of their wave
// - reload not above compare holds the wave at 1
// - enabled wave owns its pin, overriding port direction and data
// - timers 0,1 on pin a; 2,3 on pin b; inverted 2,3 on pin c
// - higher-numbered timer wins a shared pin
// - inverted outputs of timers 2 and 3 have their own enables
// - cascaded pair outputs the upper wave, gated by upper enable only
// - enable gating is not aligned to the wave; short glitch possible
// - timer 1 underflow is the serial clock source, compare ignored
// - timer 5 underflow is the display frame source, compare ignored
// - fast source codes 7..0 divide by 4096,1024,256,64,32,8,2,1
// - slow source codes 7..0 divide by 128,64,32,16,8,4,2,1
// - clock-gate bit 1 feeds the prescaled clock, 0 stops it, resets 0
// - odd timer gate bit 7, select 6..4; even gate 3, select 2..0
// - underflow reloads the counter and counting continues
// - compare match pulses when the count equals the compare value
`default_nettype none
package timer_out_pkg;
    localparam int NUM_TIMERS = 8;
    localparam int CNT_W      = 8;
    localparam int PS_W       = 12;
    localparam int FIELD_W    = 4;
    localparam int ODD_LSB    = 4;
    localparam int EVEN_LSB   = 0;

    localparam logic [15:0] IDX_PRESCALE_01 = 16'hFF14;
    localparam logic [15:0] IDX_PRESCALE_23 = 16'hFF15;
    localparam logic [15:0] IDX_PRESCALE_45 = 16'hFF18;
    localparam logic [15:0] IDX_PRESCALE_67 = 16'hFF19;
    localparam logic [15:0] IDX_SRC_SEL     = 16'hFF40;
    localparam logic [15:0] IDX_RUN         = 16'hFF41;
    localparam logic [15:0] IDX_OUT_EN      = 16'hFF42;
    localparam logic [15:0] IDX_INV_EN      = 16'hFF43;
    localparam logic [15:0] IDX_CASCADE     = 16'hFF44;
    localparam logic [15:0] IDX_WAVE_STAT   = 16'hFF45;
    localparam logic [15:0] IDX_RELOAD_BASE = 16'hFF50;
    localparam logic [15:0] IDX_COMPARE_BASE = 16'hFF60;
    localparam logic [15:0] IDX_COUNT_BASE  = 16'hFF70;

    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic [7:0] RELOAD_RST  = 8'hFF;
    localparam logic [7:0] COMPARE_RST = 8'h00;

    // division minus one, index is the select code
    localparam logic [7:0][PS_W-1:0] FAST_DIV_M1 = {12'hFFF, 12'h3FF, 12'h0FF, 12'h03F,
                                                    12'h01F, 12'h007, 12'h001, 12'h000};
    localparam logic [7:0][PS_W-1:0] SLOW_DIV_M1 = {12'h07F, 12'h03F, 12'h01F, 12'h00F,
                                                    12'h007, 12'h003, 12'h001, 12'h000};

    typedef struct packed {
        logic       gate;
        logic [2:0] sel;
    } prescale_field_t;

    typedef struct packed {
        logic out;
        logic oe_n;
    } pin_drive_t;
endpackage
`default_nettype wire

// file: timer_prescaler.sv
`default_nettype none
module timer_prescaler
    import timer_out_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            fast_tick,
    input  wire logic            slow_tick,
    input  wire logic            use_slow,
    input  wire prescale_field_t field,
    output logic                 tick
);
    logic [PS_W-1:0]    div_q;
    logic [PS_W-1:0]    cur;
    logic [PS_W-1:0]    limit;
    logic               src_tick;
    logic [FIELD_W:0]   cfg_q;

    // a new setting restarts the count, so a stale count never overshoots
    assign cur      = (cfg_q == {use_slow, field}) ? div_q : '0;
    assign limit    = use_slow ? SLOW_DIV_M1[field.sel] : FAST_DIV_M1[field.sel];
    assign src_tick = use_slow ? slow_tick : fast_tick;
    assign tick     = field.gate && src_tick && (cur == limit);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
            cfg_q <= '0;
        end else begin
            cfg_q <= {use_slow, field};
            if (!field.gate || tick) begin
                div_q <= '0;
            end else begin
                div_q <= src_tick ? cur + 1'b1 : cur;
            end
        end
    end

    gate_blocks_a: assert property (@(posedge clk) disable iff (rst)
        !field.gate |-> !tick) else $error("tick while clock gate off");
    div_one_a: assert property (@(posedge clk) disable iff (rst)
        field.gate && src_tick && field.sel == 3'h0 |-> tick)
        else $error("code 0 did not pass every source tick");
    div_slow_a: assert property (@(posedge clk) disable iff (rst)
        tick && use_slow |-> cur == SLOW_DIV_M1[field.sel])
        else $error("slow division wrong");
endmodule
`default_nettype wire

// file: timer_wave.sv
`default_nettype none
module timer_wave (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic underflow,
    input  wire logic match,
    input  wire logic hold_high,
    output logic      wave_q
);
    // events are one-cycle pulses, so acting at the next edge is their trailing edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wave_q <= 1'b0;
        end else if (hold_high) begin
            wave_q <= 1'b1;
        end else if (match) begin
            wave_q <= 1'b0;
        end else if (underflow) begin
            wave_q <= 1'b1;
        end
    end

    wave_rise_a: assert property (@(posedge clk) disable iff (rst)
        underflow && !match |=> wave_q) else $error("wave did not rise on underflow");
    wave_fall_a: assert property (@(posedge clk) disable iff (rst)
        match && !hold_high |=> !wave_q) else $error("wave did not fall on match");
    wave_held_a: assert property (@(posedge clk) disable iff (rst)
        hold_high [*2] |-> wave_q) else $error("wave not held high");
endmodule
`default_nettype wire

// file: timer_output_and_prescaler.sv
// The AHB-Lite interface to the registers was chosen for this implementation.
`default_nettype none
module timer_output_and_prescaler
    import timer_out_pkg::*;
#(
    parameter int NTIM = NUM_TIMERS
) (
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP,
    input  wire logic        FAST_OSC_TICK,
    input  wire logic        SLOW_OSC_TICK,
    input  wire logic        PORT_DIR_A,
    input  wire logic        PORT_DATA_A,
    input  wire logic        PORT_DIR_B,
    input  wire logic        PORT_DATA_B,
    input  wire logic        PORT_DIR_C,
    input  wire logic        PORT_DATA_C,
    output logic             PORT_PIN_A_O,
    output logic             PORT_PIN_A_OE_N,
    output logic             PORT_PIN_B_O,
    output logic             PORT_PIN_B_OE_N,
    output logic             PORT_PIN_C_O,
    output logic             PORT_PIN_C_OE_N,
    output logic             SERIAL_CLK_SRC,
    output logic             FRAME_CLK_SRC
);
    if (NTIM != NUM_TIMERS) begin : g_chk
        $error("pin mapping is fixed to eight timers");
    end

    // bus slave
    logic                       ap_valid_q;
    logic                       ap_write_q;
    logic                       ap_ok_q;
    logic [15:0]                ap_idx_q;
    logic                       rd_wait_q;
    logic [31:0]                rdata_q;
    logic [7:0]                 rd_mux;
    logic                       take;
    logic                       wr_en;
    logic [7:0]                 wdat;

    // software state
    logic [3:0][7:0]            prescale_q;
    logic [NTIM-1:0]            src_slow_q;
    logic [NTIM-1:0]            run_q;
    logic [NTIM-1:0]            out_en_q;
    logic [1:0]                 inv_en_q;
    logic [NTIM/2-1:0]          cascade_q;
    logic [NTIM-1:0][CNT_W-1:0] reload_q;
    logic [NTIM-1:0][CNT_W-1:0] compare_q;

    // timer state
    logic [NTIM-1:0][CNT_W-1:0] cnt_q;
    logic [NTIM-1:0][CNT_W-1:0] cnt_d;
    logic [NTIM-1:0]            cnt_tick;
    logic [NTIM-1:0]            uf8;
    logic [NTIM-1:0]            match_ev;
    logic [NTIM-1:0]            wave;

    pin_drive_t                 pin_a_q;
    pin_drive_t                 pin_b_q;
    pin_drive_t                 pin_c_q;
    logic                       serial_q;
    logic                       frame_q;

    assign take  = HSEL && HTRANS[1] && HREADY;
    assign wr_en = ap_valid_q && ap_write_q && ap_ok_q;
    assign wdat  = HWDATA[7:0];

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_ok_q    <= 1'b0;
            ap_idx_q   <= '0;
            rd_wait_q  <= 1'b0;
        end else begin
            ap_valid_q <= take;
            rd_wait_q  <= take && !HWRITE;
            if (take) begin
                ap_write_q <= HWRITE;
                ap_idx_q   <= HADDR[17:2];
                ap_ok_q    <= (HADDR[31:18] == 14'h0000) && (HADDR[1:0] == 2'h0);
            end
        end
    end

    // one wait state on reads so the value is taken after any write ahead of it
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_q <= '0;
        end else if (rd_wait_q) begin
            rdata_q <= ap_ok_q ? {24'h000000, rd_mux} : 32'h00000000;
        end
    end

    // only a read data phase waits
    assign HREADYOUT = !rd_wait_q;
    assign HRDATA    = rdata_q;
    assign HRESP     = 1'b0;

    always_comb begin
        rd_mux = 8'h00;
        case (ap_idx_q)
            IDX_PRESCALE_01: rd_mux = prescale_q[0];
            IDX_PRESCALE_23: rd_mux = prescale_q[1];
            IDX_PRESCALE_45: rd_mux = prescale_q[2];
            IDX_PRESCALE_67: rd_mux = prescale_q[3];
            IDX_SRC_SEL:     rd_mux = src_slow_q;
            IDX_RUN:         rd_mux = run_q;
            IDX_OUT_EN:      rd_mux = out_en_q;
            IDX_INV_EN:      rd_mux = {6'h00, inv_en_q};
            IDX_CASCADE:     rd_mux = {4'h0, cascade_q};
            IDX_WAVE_STAT:   rd_mux = wave;
            default: begin
                if (ap_idx_q[15:3] == IDX_RELOAD_BASE[15:3]) begin
                    rd_mux = reload_q[ap_idx_q[2:0]];
                end else if (ap_idx_q[15:3] == IDX_COMPARE_BASE[15:3]) begin
                    rd_mux = compare_q[ap_idx_q[2:0]];
                end else if (ap_idx_q[15:3] == IDX_COUNT_BASE[15:3]) begin
                    rd_mux = cnt_q[ap_idx_q[2:0]];
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            prescale_q <= {4{REG_RST}};
        end else if (wr_en) begin
            case (ap_idx_q)
                IDX_PRESCALE_01: prescale_q[0] <= wdat;
                IDX_PRESCALE_23: prescale_q[1] <= wdat;
                IDX_PRESCALE_45: prescale_q[2] <= wdat;
                IDX_PRESCALE_67: prescale_q[3] <= wdat;
                default: prescale_q <= prescale_q;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            src_slow_q <= REG_RST;
            run_q      <= REG_RST;
            out_en_q   <= REG_RST;
            inv_en_q   <= REG_RST[1:0];
            cascade_q  <= REG_RST[3:0];
        end else if (wr_en) begin
            case (ap_idx_q)
                IDX_SRC_SEL: src_slow_q <= wdat;
                IDX_RUN:     run_q      <= wdat;
                IDX_OUT_EN:  out_en_q   <= wdat;
                IDX_INV_EN:  inv_en_q   <= wdat[1:0];
                IDX_CASCADE: cascade_q  <= wdat[3:0];
                default:     run_q      <= run_q;
            endcase
        end
    end

    for (genvar t = 0; t < NTIM; t++) begin : g_tim
        localparam int PAIR   = t / 2;
        localparam int MATE   = t ^ 1;
        localparam bit IS_ODD = (t % 2) == 1;

        prescale_field_t field;
        logic            ps_tick;
        logic            upper;
        logic            lower;
        logic            reload_now;
        logic            hold_high;

        assign field = IS_ODD ? prescale_q[PAIR][ODD_LSB +: FIELD_W]
                              : prescale_q[PAIR][EVEN_LSB +: FIELD_W];
        assign upper = IS_ODD && cascade_q[PAIR];
        assign lower = !IS_ODD && cascade_q[PAIR];

        timer_prescaler u_ps (
            .clk       (CLK_SYS),
            .rst       (SYS_RST),
            .fast_tick (FAST_OSC_TICK),
            .slow_tick (SLOW_OSC_TICK),
            .use_slow  (src_slow_q[t]),
            .field     (field),
            .tick      (ps_tick)
        );

        // the upper half of a pair counts borrows of the lower half
        assign cnt_tick[t] = upper ? uf8[MATE] : (run_q[t] && ps_tick);
        assign uf8[t]      = cnt_tick[t] && (cnt_q[t] == '0);

        // lower half wraps through zero; both reload only on the full borrow
        assign reload_now  = lower ? uf8[MATE] : uf8[t];
        assign cnt_d[t]    = !cnt_tick[t] ? cnt_q[t]
                           : (reload_now ? reload_q[t] : cnt_q[t] - 1'b1);

        always_comb begin
            if (upper) begin
                match_ev[t] = cnt_tick[MATE] && (cnt_d[MATE] == compare_q[MATE])
                              && (cnt_d[t] == compare_q[t]);
                hold_high   = {reload_q[t], reload_q[MATE]}
                              <= {compare_q[t], compare_q[MATE]};
            end else begin
                match_ev[t] = cnt_tick[t] && (cnt_d[t] == compare_q[t]);
                hold_high   = reload_q[t] <= compare_q[t];
            end
        end

        always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
            if (SYS_RST) begin
                cnt_q[t] <= RELOAD_RST;
            end else begin
                cnt_q[t] <= cnt_d[t];
            end
        end

        always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
            if (SYS_RST) begin
                reload_q[t]  <= RELOAD_RST;
                compare_q[t] <= COMPARE_RST;
            end else if (wr_en && ap_idx_q[2:0] == 3'(t)) begin
                if (ap_idx_q[15:3] == IDX_RELOAD_BASE[15:3]) begin
                    reload_q[t] <= wdat;
                end
                if (ap_idx_q[15:3] == IDX_COMPARE_BASE[15:3]) begin
                    compare_q[t] <= wdat;
                end
            end
        end

        timer_wave u_wave (
            .clk       (CLK_SYS),
            .rst       (SYS_RST),
            .underflow (uf8[t] && !lower),
            .match     (match_ev[t]),
            .hold_high (hold_high),
            .wave_q    (wave[t])
        );

        reload_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
            uf8[t] && !lower |=> cnt_q[t] == $past(reload_q[t]))
            else $error("counter not reloaded on underflow");
    end

    // pin muxing; enables act straight on the pin, so a partial wave cycle may escape
    logic own_a;
    logic own_b;
    logic own_c;

    assign own_a = out_en_q[1] || (out_en_q[0] && !cascade_q[0]);
    assign own_b = out_en_q[3] || (out_en_q[2] && !cascade_q[1]);
    assign own_c = inv_en_q[1] || (inv_en_q[0] && !cascade_q[1]);

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_a_q <= '{out: 1'b0, oe_n: 1'b1};
            pin_b_q <= '{out: 1'b0, oe_n: 1'b1};
            pin_c_q <= '{out: 1'b0, oe_n: 1'b1};
        end else begin
            pin_a_q.out  <= own_a ? (out_en_q[1] ? wave[1] : wave[0]) : PORT_DATA_A;
            pin_a_q.oe_n <= own_a ? 1'b0 : !PORT_DIR_A;
            pin_b_q.out  <= own_b ? (out_en_q[3] ? wave[3] : wave[2]) : PORT_DATA_B;
            pin_b_q.oe_n <= own_b ? 1'b0 : !PORT_DIR_B;
            pin_c_q.out  <= own_c ? (inv_en_q[1] ? !wave[3] : !wave[2]) : PORT_DATA_C;
            pin_c_q.oe_n <= own_c ? 1'b0 : !PORT_DIR_C;
        end
    end

    assign PORT_PIN_A_O    = pin_a_q.out;
    assign PORT_PIN_A_OE_N = pin_a_q.oe_n;

    assign PORT_PIN_B_O    = pin_b_q.out;
    assign PORT_PIN_B_OE_N = pin_b_q.oe_n;

    assign PORT_PIN_C_O    = pin_c_q.out;
    assign PORT_PIN_C_OE_N = pin_c_q.oe_n;

    // compare value has no bearing on these sources
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            serial_q <= 1'b0;
            frame_q  <= 1'b0;
        end else begin
            serial_q <= uf8[1];
            frame_q  <= uf8[5];
        end
    end

    assign SERIAL_CLK_SRC = serial_q;
    assign FRAME_CLK_SRC  = frame_q;

    pin_a_owner_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        out_en_q[1] |=> PORT_PIN_A_O == $past(wave[1]) && !PORT_PIN_A_OE_N)
        else $error("timer 1 does not own pin a");

    pin_b_owner_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        out_en_q[2] && !out_en_q[3] && !cascade_q[1]
        |=> PORT_PIN_B_O == $past(wave[2]) && !PORT_PIN_B_OE_N)
        else $error("timer 2 wave missing on pin b");

    pin_c_inv_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        inv_en_q[1] |=> PORT_PIN_C_O == !$past(wave[3]) && !PORT_PIN_C_OE_N)
        else $error("pin c is not the inverted wave");

    port_idle_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !own_a |=> PORT_PIN_A_O == $past(PORT_DATA_A) && PORT_PIN_A_OE_N == !$past(PORT_DIR_A))
        else $error("pin a not under port control");

    pin_b_idle_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !own_b |=> PORT_PIN_B_O == $past(PORT_DATA_B) && PORT_PIN_B_OE_N == !$past(PORT_DIR_B))
        else $error("pin b not under port control");

    pin_c_idle_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !own_c |=> PORT_PIN_C_O == $past(PORT_DATA_C) && PORT_PIN_C_OE_N == !$past(PORT_DIR_C))
        else $error("pin c not under port control");

    cascade_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        cascade_q[0] && out_en_q[0] && !out_en_q[1] |=> PORT_PIN_A_OE_N == !$past(PORT_DIR_A))
        else $error("lower timer of a pair drove pin a");

    serial_src_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        uf8[1] |=> SERIAL_CLK_SRC ##1 !SERIAL_CLK_SRC || $past(uf8[1]))
        else $error("serial source pulse wrong");

    frame_src_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        SERIAL_CLK_SRC == $past(uf8[1]) && FRAME_CLK_SRC == $past(uf8[5]))
        else $error("frame source not timer 5 underflow");

    read_wait_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
endmodule
`default_nettype wire

// file: wave_receiver.sv
`default_nettype none
// pin load: counts rises and high cycles while driven
module wave_receiver (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_o,
    input  wire logic pin_oe_n,
    output logic      level,
    output int        rises = 0,
    output int        highs = 0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_q = 1'b0;

    // no pull: a released pin shows a toggling level
    assign level = (pin_oe_n === 1'b0) ? pin_o : ~last_q;

    always @(posedge clk) begin
        if (rst) begin
            last_q <= 1'b0;
        end else if (pin_oe_n === 1'b0) begin
            if (pin_o === 1'b1 && last_q === 1'b0) begin
                rises <= rises + 1;
            end
            if (pin_o === 1'b1) begin
                highs <= highs + 1;
            end
            last_q <= pin_o;
        end else begin
            last_q <= ~last_q;
        end
    end
endmodule
`default_nettype wire

// file: timer_output_and_prescaler_tb.sv
`default_nettype none
module timer_output_and_prescaler_tb
    import timer_out_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, hsel, hwrite, hreadyout, hresp, fast_tick, slow_tick;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0]  htrans;
    logic [2:0]  pdir, pdat, pin_o, pin_oe_n, lvl;
    logic        ser_clk, frm_clk;
    int          rises[3], highs[3], d_r[3], d_h[3];
    int          ser_n, frm_n, d_s, d_f, err_total, checks;
    int          fd[8] = '{1, 2, 8, 32, 64, 256, 1024, 4096};
    int          sd[8] = '{1, 2, 4, 8, 16, 32, 64, 128};

    timer_output_and_prescaler dut (.CLK_SYS(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .FAST_OSC_TICK(fast_tick),
        .SLOW_OSC_TICK(slow_tick), .PORT_DIR_A(pdir[0]), .PORT_DATA_A(pdat[0]),
        .PORT_DIR_B(pdir[1]), .PORT_DATA_B(pdat[1]), .PORT_DIR_C(pdir[2]),
        .PORT_DATA_C(pdat[2]), .PORT_PIN_A_O(pin_o[0]), .PORT_PIN_A_OE_N(pin_oe_n[0]),
        .PORT_PIN_B_O(pin_o[1]), .PORT_PIN_B_OE_N(pin_oe_n[1]), .PORT_PIN_C_O(pin_o[2]),
        .PORT_PIN_C_OE_N(pin_oe_n[2]), .SERIAL_CLK_SRC(ser_clk), .FRAME_CLK_SRC(frm_clk));
    wave_receiver p_a (.clk(clk), .rst(rst), .pin_o(pin_o[0]), .pin_oe_n(pin_oe_n[0]),
        .level(lvl[0]), .rises(rises[0]), .highs(highs[0]));
    wave_receiver p_b (.clk(clk), .rst(rst), .pin_o(pin_o[1]), .pin_oe_n(pin_oe_n[1]),
        .level(lvl[1]), .rises(rises[1]), .highs(highs[1]));
    wave_receiver p_c (.clk(clk), .rst(rst), .pin_o(pin_o[2]), .pin_oe_n(pin_oe_n[2]),
        .level(lvl[2]), .rises(rises[2]), .highs(highs[2]));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        if (ser_clk === 1'b1) ser_n <= ser_n + 1;
        if (frm_clk === 1'b1) frm_n <= frm_n + 1;
    end

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // bounded wait for hready high at an edge
    task automatic rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            err_total++;
            $display("[ERR] hready expected 1 seen timeout");
            summarize();
        end
    endtask

    task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        rdy();
        rdat = hrdata;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rd(input string what, input logic [15:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        chk(what, {24'h0, exp}, rdat);
    endtask

    // whole-period windows make counts phase independent
    task automatic win(input int n);
        int r0[3], h0[3], s0, f0;
        r0 = rises;
        h0 = highs;
        s0 = ser_n;
        f0 = frm_n;
        repeat (n) @(posedge clk);
        foreach (d_r[i]) begin
            d_r[i] = rises[i] - r0[i];
            d_h[i] = highs[i] - h0[i];
        end
        d_s = ser_n - s0;
        d_f = frm_n - f0;
    endtask

    task automatic t_reset;
        chk("pin a oe_n", 1'b1, pin_oe_n[0]);
        chk("pin b oe_n", 1'b1, pin_oe_n[1]);
        chk("pin c oe_n", 1'b1, pin_oe_n[2]);
        chk("pin outs", 3'b000, pin_o);
        rd("prescale 01", IDX_PRESCALE_01, 8'h00);
        rd("prescale 23", IDX_PRESCALE_23, 8'h00);
        rd("prescale 45", IDX_PRESCALE_45, 8'h00);
        chk("hresp", 1'b0, hresp);
        $display("test reset finished");
    endtask

    task automatic t_regs;
        wr(IDX_PRESCALE_01, 8'hA5);
        wr(IDX_PRESCALE_23, 8'h5A);
        wr(IDX_PRESCALE_45, 8'hFF);
        wr(16'h0100, 8'h77);
        rd("prescale 01", IDX_PRESCALE_01, 8'hA5);
        rd("prescale 23", IDX_PRESCALE_23, 8'h5A);
        rd("prescale 45", IDX_PRESCALE_45, 8'hFF);
        rd("unmapped", 16'h0100, 8'h00);
        $display("test registers finished");
    endtask

    task automatic t_port;
        pdir[0] <= 1'b1;
        pdat[0] <= 1'b1;
        repeat (3) @(posedge clk);
        chk("dc a oe_n", 1'b0, pin_oe_n[0]);
        chk("dc a out", 1'b1, pin_o[0]);
        pdat[0] <= 1'b0;
        $display("test port finished");
    endtask

    task automatic t_wave;
        int h1;
        wr(IDX_RELOAD_BASE + 16'h1, 8'h04);
        wr(IDX_COMPARE_BASE + 16'h1, 8'h01);
        wr(IDX_PRESCALE_01, 8'h80);
        wr(IDX_RUN, 8'h02);
        wr(IDX_OUT_EN, 8'h02);
        repeat (300) @(posedge clk);
        win(20);
        chk("a rises", 4, d_r[0]);
        chk("serial pulses", 4, d_s);
        chk("a oe_n", 1'b0, pin_oe_n[0]);
        h1 = d_h[0];
        wr(IDX_COMPARE_BASE + 16'h1, 8'h03);
        repeat (10) @(posedge clk);
        win(20);
        chk("serial pulses", 4, d_s);
        chk("duty step", 8, h1 - d_h[0]);
        wr(IDX_COMPARE_BASE + 16'h1, 8'h04);
        repeat (10) @(posedge clk);
        win(20);
        chk("a highs", 20, d_h[0]);
        $display("test wave finished");
    endtask

    task automatic t_share;
        pdir[2] <= 1'b1;
        pdat[2] <= 1'b1;
        wr(IDX_RELOAD_BASE + 16'h2, 8'h04);
        wr(IDX_COMPARE_BASE + 16'h2, 8'h01);
        wr(IDX_RELOAD_BASE + 16'h3, 8'h01);
        wr(IDX_COMPARE_BASE + 16'h3, 8'h03);
        wr(IDX_PRESCALE_23, 8'h88);
        wr(IDX_RUN, 8'h0E);
        wr(IDX_OUT_EN, 8'h04);
        wr(IDX_INV_EN, 8'h01);
        repeat (300) @(posedge clk);
        win(20);
        chk("b rises", 4, d_r[1]);
        chk("c rises", 4, d_r[2]);
        chk("b plus c highs", 20, d_h[1] + d_h[2]);
        chk("a oe_n", 1'b0, pin_oe_n[0]);
        wr(IDX_OUT_EN, 8'h0C);
        wr(IDX_INV_EN, 8'h03);
        repeat (5) @(posedge clk);
        win(20);
        chk("b highs", 20, d_h[1]);
        chk("c highs", 0, d_h[2]);
        wr(IDX_INV_EN, 8'h00);
        wr(IDX_CASCADE, 8'h03);
        wr(IDX_OUT_EN, 8'h05);
        repeat (3) @(posedge clk);
        chk("cascade low oe_n", 1'b1, pin_oe_n[1]);
        wr(IDX_OUT_EN, 8'h08);
        repeat (3) @(posedge clk);
        chk("cascade high oe_n", 1'b0, pin_oe_n[1]);
        wr(IDX_CASCADE, 8'h00);
        $display("test shared pins finished");
    endtask

    task automatic t_presc;
        int n;
        wr(IDX_RELOAD_BASE + 16'h1, 8'h00);
        wr(IDX_PRESCALE_01, 8'h00);
        repeat (10) @(posedge clk);
        win(64);
        chk("gated pulses", 0, d_s);
        wr(IDX_RELOAD_BASE + 16'h5, 8'h01);
        wr(IDX_COMPARE_BASE + 16'h5, 8'h07);
        wr(IDX_PRESCALE_45, 8'h80);
        wr(IDX_RUN, 8'h22);
        for (int i = 0; i < 16; i++) begin
            if (i == 8) begin
                fast_tick <= 1'b0;
                wr(IDX_SRC_SEL, 8'h02);
            end
            n = (i < 8) ? fd[i] : sd[i-8];
            wr(IDX_PRESCALE_01, {1'b1, i[2:0], 4'h0});
            repeat (n + 8) @(posedge clk);
            if (i == 0) begin
                repeat (300) @(posedge clk);
                win(64);
                chk("frame pulses", 32, d_f);
            end
            win((n < 128) ? 512 : 4 * n);
            chk("divided pulses", ((n < 128) ? 512 : 4 * n) / n, d_s);
        end
        $display("test prescaler finished");
    endtask

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        fast_tick = 1'b1;
        slow_tick = 1'b1;
        pdir = 3'b000;
        pdat = 3'b000;
        err_total = 0;
        checks = 0;
        ser_n = 0;
        frm_n = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_regs();
        t_port();
        t_wave();
        t_share();
        t_presc();
        summarize();
    end
endmodule
`default_nettype wire
